// ---- rtl/sew_ctl.sv ----
// Bus controller end: byte/page writes with acknowledge polling, and
// the protocol recovery sequence. Assumes sew_link_if on the link side.
`timescale 1ns/100ps
`default_nettype none
module sew_ctl #(
    parameter int QUARTER = sew_pkg::Q_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    // Link
    sew_link_if.ctl                         link,
    // Command
    input  wire logic                       cmd_valid_i,
    output logic                            cmd_ready_o,
    input  wire logic                       cmd_recover_i,
    input  wire logic [2:0]                 cmd_sel_i,
    input  wire logic [sew_pkg::ADDR_W-1:0] cmd_addr_i,
    input  wire logic [6:0]                 cmd_len_i,
    // Write data stream
    input  wire logic [7:0]                 wr_data_i,
    input  wire logic                       wr_valid_i,
    output logic                            wr_ready_o,
    // Completion
    output logic                            done_o,
    output logic                            nack_o
);
    import sew_pkg::*;

    // Device needs two sync stages plus an edge stage per quarter
    if (QUARTER < 4) begin : g_chk
        $error("QUARTER must be at least 4");
    end

    sew_cst_e                  st;
    logic [$clog2(QUARTER)-1:0] tick_cnt;
    logic [1:0]                q;
    logic [3:0]                bit_cnt;
    logic [1:0]                sel;
    logic [6:0]                left;
    logic [7:0]                shreg;
    logic [7:0]                tx_next;
    logic [2:0]                sel_q;
    logic [ADDR_W-1:0]         addr_q;
    logic                      recov;
    logic                      rstage;
    logic                      polling;
    logic                      repoll;
    logic                      err;
    logic                      got;
    logic                      sda_s1;
    logic                      sda_s2;
    logic [7:0]                fifo [2];
    logic                      wr_ptr;
    logic                      rd_ptr;
    logic [1:0]                fifo_cnt;
    logic [1:0]                next_fifo_cnt;
    logic                      tick;
    logic                      loading;
    logic                      stall;
    logic                      adv;
    logic                      push;
    logic                      pop;
    logic                      bit_val;

    assign link.ctl_sda_o = 1'b0;
    assign tick    = tick_cnt == ($clog2(QUARTER))'(QUARTER - 1);
    assign loading = (st == CST_BYTE) && (q == 2'h0) && (bit_cnt == 4'h0);
    // Clock is held low while the buffer is empty
    assign stall   = loading && !recov && (sel == POS_DATA) && (fifo_cnt == 2'h0);
    assign adv     = tick && !stall;
    assign push    = wr_valid_i && wr_ready_o;
    assign pop     = adv && loading && !recov && (sel == POS_DATA);
    assign bit_val = loading ? tx_next[7] : shreg[7];

    always_comb begin
        tx_next = fifo[rd_ptr];
        if (recov) begin
            tx_next = RECOV_BYTE;
        end else if (sel == POS_DEV) begin
            tx_next = {DEV_CODE, sel_q, 1'b0};
        end else if (sel == POS_AH) begin
            tx_next = {1'b0, addr_q[14:8]};
        end else if (sel == POS_AL) begin
            tx_next = addr_q[7:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            sda_s1 <= link.sda;
            sda_s2 <= sda_s1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt <= '0;
        end else if (st == CST_IDLE || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    always_comb begin
        next_fifo_cnt = fifo_cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr     <= 1'b0;
            rd_ptr     <= 1'b0;
            fifo_cnt   <= 2'h0;
            wr_ready_o <= 1'b1;
        end else begin
            if (push) begin
                fifo[wr_ptr] <= wr_data_i;
                wr_ptr       <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            fifo_cnt   <= next_fifo_cnt;
            wr_ready_o <= next_fifo_cnt != 2'h2;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st          <= CST_IDLE;
            q           <= 2'h0;
            bit_cnt     <= 4'h0;
            sel         <= POS_DEV;
            left        <= 7'h0;
            shreg       <= 8'h0;
            sel_q       <= 3'h0;
            addr_q      <= '0;
            recov       <= 1'b0;
            rstage      <= 1'b0;
            polling     <= 1'b0;
            repoll      <= 1'b0;
            err         <= 1'b0;
            got         <= 1'b1;
            link.scl    <= 1'b1;
            link.ctl_sda_oe <= 1'b0;
            cmd_ready_o <= 1'b1;
            done_o      <= 1'b0;
            nack_o      <= 1'b0;
        end else begin
            done_o <= 1'b0;
            nack_o <= 1'b0;
            if (st == CST_IDLE) begin
                if (cmd_valid_i && cmd_ready_o) begin
                    st          <= CST_START;
                    cmd_ready_o <= 1'b0;
                    q           <= 2'h0;
                    sel         <= POS_DEV;
                    sel_q       <= cmd_sel_i;
                    addr_q      <= cmd_addr_i;
                    left        <= cmd_len_i;
                    recov       <= cmd_recover_i;
                    rstage      <= 1'b0;
                    polling     <= 1'b0;
                    repoll      <= 1'b0;
                    err         <= 1'b0;
                end
            end else if (adv) begin
                q <= q + 2'h1;
                unique case (st)
                    CST_START: begin
                        if (q == 2'h0) begin
                            // Clock left as it is: lowering it here gives a one-quarter low pulse
                            link.ctl_sda_oe <= 1'b0;
                        end else if (q == 2'h1) begin
                            link.scl <= 1'b1;
                        end else if (q == 2'h2) begin
                            link.ctl_sda_oe <= 1'b1;
                        end else begin
                            link.scl <= 1'b0;
                            bit_cnt  <= 4'h0;
                            // Second start of the recovery goes straight to stop
                            st <= (recov && rstage) ? CST_STOP : CST_BYTE;
                        end
                    end
                    CST_BYTE: begin
                        if (q == 2'h0) begin
                            link.scl        <= 1'b0;
                            link.ctl_sda_oe <= (bit_cnt != ACK_BIT) && !bit_val;
                            if (loading) begin
                                shreg <= tx_next;
                            end
                        end else if (q == 2'h1) begin
                            link.scl <= 1'b1;
                        end else if (q == 2'h2) begin
                            got <= sda_s2;
                        end else begin
                            link.scl <= 1'b0;
                            if (bit_cnt != ACK_BIT) begin
                                shreg   <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end else if (recov) begin
                                rstage <= 1'b1;
                                st     <= CST_START;
                            end else if (got || polling || (sel == POS_DATA && left == 7'h1)) begin
                                st     <= CST_STOP;
                                err    <= got && !polling;
                                // Polling repeats until the device answers
                                repoll <= polling ? got : !got;
                            end else begin
                                bit_cnt <= 4'h0;
                                sel     <= (sel == POS_DATA) ? POS_DATA : sel + 2'h1;
                                if (sel == POS_DATA) begin
                                    left <= left - 7'h1;
                                end
                            end
                        end
                    end
                    CST_STOP: begin
                        if (q == 2'h0) begin
                            link.scl        <= 1'b0;
                            link.ctl_sda_oe <= 1'b1;
                        end else if (q == 2'h1) begin
                            link.scl <= 1'b1;
                        end else if (q == 2'h2) begin
                            link.ctl_sda_oe <= 1'b0;
                        end else if (repoll) begin
                            st      <= CST_START;
                            polling <= 1'b1;
                            sel     <= POS_DEV;
                        end else begin
                            st          <= CST_IDLE;
                            cmd_ready_o <= 1'b1;
                            done_o      <= 1'b1;
                            nack_o      <= err;
                        end
                    end
                    default: begin
                        st <= CST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : sew_ctl
`default_nettype wire

// ---- rtl/sew_pkg.sv ----
// Shared constants and state types for both ends of the two-wire memory link.
// Assumes a 25 MHz system clock on both ends.
package sew_pkg;

    localparam int CLK_HZ     = 25_000_000;
    localparam int T_WR_MS    = 5;
    localparam int WR_CYCLES  = T_WR_MS * (CLK_HZ / 1000);
    localparam int Q_CYCLES   = 4;
    localparam int ADDR_W     = 15;
    localparam int PAGE_W     = 6;
    localparam int PAGE_BYTES = 64;

    localparam logic [3:0] DEV_CODE = 4'ha;
    localparam logic [3:0] ACK_BIT  = 4'h8;
    localparam logic [7:0] RECOV_BYTE = 8'hff;

    // Byte position inside a write frame
    localparam logic [1:0] POS_DEV  = 2'h0;
    localparam logic [1:0] POS_AH   = 2'h1;
    localparam logic [1:0] POS_AL   = 2'h2;
    localparam logic [1:0] POS_DATA = 2'h3;

    typedef enum logic [3:0] {
        DST_IDLE = 4'h1,
        DST_RECV = 4'h2,
        DST_ACK  = 4'h4,
        DST_BUSY = 4'h8
    } sew_dst_e;

    typedef enum logic [3:0] {
        CST_IDLE  = 4'h1,
        CST_START = 4'h2,
        CST_BYTE  = 4'h4,
        CST_STOP  = 4'h8
    } sew_cst_e;

endpackage : sew_pkg

// ---- rtl/sew_link_if.sv ----
// Two-wire link between the bus controller and the memory target.
// Open-drain data line with a pull-up; clock driven by the controller only.
`timescale 1ns/100ps
`default_nettype none
interface sew_link_if;
    logic scl;
    logic ctl_sda_o;
    logic ctl_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Pull-up wins unless someone pulls low
    assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe, input sda);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : sew_link_if
`default_nettype wire

// ---- rtl/sew_target.sv ----
// Memory target end: start/stop detection, device select, byte and page
// writes into a page buffer, then a self-timed commit into the array.
// Assumes sew_link_if on the link side and a clock well above the link rate.
`timescale 1ns/100ps
`default_nettype none
module sew_target #(
    parameter int WR_CYCLES = sew_pkg::WR_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    // Link
    sew_link_if.dev                         link,
    // Straps
    input  wire logic [2:0]                 hw_select_pins_i,
    input  wire logic                       write_protect_i,
    // Array readback
    input  wire logic [sew_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [7:0]                      rd_data_o,
    // Status
    output logic                            standby_o,
    output logic                            busy_o
);
    import sew_pkg::*;

    localparam int CNT_W = $clog2(WR_CYCLES + 1);

    // Commit walks the page one byte per cycle inside the write time
    if (WR_CYCLES < PAGE_BYTES) begin : g_chk
        $error("WR_CYCLES must cover one page");
    end

    sew_dst_e          st;
    sew_dst_e          next_st;
    logic [5:0]        sync1;
    logic [5:0]        sync2;
    logic              scl_p;
    logic              sda_p;
    logic              scl_s;
    logic              sda_s;
    logic              wp_s;
    logic [2:0]        pins_s;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic [3:0]        bit_cnt;
    logic [7:0]        shreg;
    logic [1:0]        pos;
    logic              rd_q;
    logic              dev_match;
    logic              ack_ok;
    logic              byte_done;
    logic              wr_byte;
    logic              go_busy;
    logic              busy_end;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0]  busy_cnt;
    logic [7:0]        pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask;
    logic [7:0]        mem [2**ADDR_W];

    assign link.dev_sda_o = 1'b0;

    // Pins and link wires come from outside this clock
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1 <= 6'h30;
            sync2 <= 6'h30;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            sync1 <= {link.scl, link.sda, write_protect_i, hw_select_pins_i};
            sync2 <= sync1;
            scl_p <= sync2[5];
            sda_p <= sync2[4];
        end
    end

    assign scl_s  = sync2[5];
    assign sda_s  = sync2[4];
    // Select and protect pins reset low, as floating pins do
    assign wp_s   = sync2[3];
    assign pins_s = sync2[2:0];

    assign scl_rise  = scl_s && !scl_p;
    assign scl_fall  = !scl_s && scl_p;
    // Data edges under a high clock are never bits
    assign start_det = scl_s && scl_p && sda_p && !sda_s;
    assign stop_det  = scl_s && scl_p && !sda_p && sda_s;

    assign dev_match = (shreg[7:4] == DEV_CODE) && (shreg[3:1] == pins_s);
    assign ack_ok    = (pos != POS_DEV) || dev_match;
    assign byte_done = (st == DST_RECV) && scl_fall && (bit_cnt == ACK_BIT);
    assign wr_byte   = byte_done && (pos == POS_DATA);
    assign go_busy   = (|mask) && !wp_s;
    assign busy_end  = busy_cnt == CNT_W'(WR_CYCLES - 1);

    always_comb begin
        next_st = st;
        unique case (st)
            DST_IDLE: begin
                if (start_det) begin
                    next_st = DST_RECV;
                end
            end
            DST_RECV: begin
                if (start_det) begin
                    next_st = DST_RECV;
                end else if (stop_det) begin
                    next_st = go_busy ? DST_BUSY : DST_IDLE;
                end else if (byte_done) begin
                    next_st = ack_ok ? DST_ACK : DST_IDLE;
                end
            end
            DST_ACK: begin
                if (start_det) begin
                    next_st = DST_RECV;
                end else if (stop_det) begin
                    next_st = go_busy ? DST_BUSY : DST_IDLE;
                end else if (scl_fall) begin
                    // Read data path is not built; a read frame ends here
                    next_st = (pos == POS_DEV && rd_q) ? DST_IDLE : DST_RECV;
                end
            end
            DST_BUSY: begin
                // Start, stop and bits all ignored until the cycle ends
                if (busy_end) begin
                    next_st = DST_IDLE;
                end
            end
            default: begin
                next_st = DST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st              <= DST_IDLE;
            link.dev_sda_oe <= 1'b0;
            standby_o       <= 1'b1;
            busy_o          <= 1'b0;
        end else begin
            st              <= next_st;
            link.dev_sda_oe <= next_st == DST_ACK;
            standby_o       <= next_st == DST_IDLE;
            busy_o          <= next_st == DST_BUSY;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt <= 4'h0;
            shreg   <= 8'h0;
            pos     <= POS_DEV;
            rd_q    <= 1'b0;
        end else if (st != DST_BUSY) begin
            if (start_det) begin
                bit_cnt <= 4'h0;
                pos     <= POS_DEV;
            end else if (st == DST_RECV && scl_rise && bit_cnt != ACK_BIT) begin
                shreg   <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done && pos == POS_DEV) begin
                rd_q <= shreg[0];
            end else if (st == DST_ACK && scl_fall) begin
                bit_cnt <= 4'h0;
                pos     <= (pos == POS_DATA) ? POS_DATA : pos + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr <= '0;
            mask <= '0;
        end else if (st == DST_BUSY) begin
            if (busy_end) begin
                mask <= '0;
            end
        end else if (stop_det && !go_busy) begin
            mask <= '0;
        end else if (byte_done && pos == POS_DEV && dev_match && !shreg[0]) begin
            mask <= '0;
        end else if (byte_done && pos == POS_AH) begin
            addr[14:8] <= shreg[6:0];
        end else if (byte_done && pos == POS_AL) begin
            addr[7:0] <= shreg;
        end else if (wr_byte) begin
            mask[addr[PAGE_W-1:0]] <= 1'b1;
            addr[PAGE_W-1:0]       <= addr[PAGE_W-1:0] + 6'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_byte && st != DST_BUSY) begin
            pbuf[addr[PAGE_W-1:0]] <= shreg;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_cnt <= '0;
        end else if (st == DST_BUSY && !busy_end) begin
            busy_cnt <= busy_cnt + 1'b1;
        end else begin
            busy_cnt <= '0;
        end
    end

    // Page row stays fixed; only buffered bytes are committed
    always_ff @(posedge clk_i) begin
        if (st == DST_BUSY && busy_cnt < CNT_W'(PAGE_BYTES) && mask[busy_cnt[PAGE_W-1:0]]) begin
            mem[{addr[ADDR_W-1:PAGE_W], busy_cnt[PAGE_W-1:0]}] <= pbuf[busy_cnt[PAGE_W-1:0]];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 8'h0;
        end else begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule : sew_target
`default_nettype wire

// ---- tb/sew_link_sva.sv ----
// Link checker: bit timing, acknowledge shape, start and stop framing.
// Assumes QUARTER=4 on the controller, so one bit spans 16 clocks.
`timescale 1ns/100ps
`default_nettype none
module sew_link_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Link signals
    input wire logic scl,
    input wire logic ctl_sda_o,
    input wire logic ctl_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_start; scl && $fell(sda); endsequence
    sequence s_stop; scl && $rose(sda); endsequence
    sequence s_ack; dev_sda_oe [*8] ##[1:8] (scl && dev_sda_oe); endsequence

    a_drive_low_only: assert property (!ctl_sda_o && !dev_sda_o)
        else $error("sda driven high");
    a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("target moved sda with scl high");
    a_ctl_edges_apart: assert property ($changed(ctl_sda_oe) |-> $stable(scl))
        else $error("controller moved sda and scl together");
    a_scl_low_width: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase too short");
    a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase too short");
    a_ack_holds_clock: assert property ($rose(dev_sda_oe) |-> s_ack)
        else $error("acknowledge not held over ninth clock");
    a_ack_released: assert property ($rose(dev_sda_oe) |-> ##[10:30] !dev_sda_oe)
        else $error("acknowledge not released");
    a_no_contention: assert property (dev_sda_oe && scl |-> !ctl_sda_oe)
        else $error("controller drives during acknowledge");
    a_stop_idle: assert property (s_stop |-> scl [*4])
        else $error("scl not idle after stop");
    a_start_then_low: assert property (s_start |-> ##[1:12] (!scl || sda))
        else $error("start not followed by clocking or stop");
    a_quiet_after_start: assert property (s_start |-> !dev_sda_oe [*8])
        else $error("target drove sda right after start");
endmodule : sew_link_sva
`default_nettype wire

// ---- tb/serial_eeprom_write_slave_bench.sv ----
// Bench joining controller and target over one link; checks the array.
// Assumes the sew_pkg package and a short write cycle of 200 clocks.
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_write_slave_bench;
    import sew_pkg::*;
    localparam int WRC = 200;
    logic              clk_i, sys_rst_i, cmd_valid_i, cmd_ready_o, cmd_recover_i, wp;
    logic              wr_valid_i, wr_ready_o, done_o, nack_o, standby_o, busy_o, nk;
    logic [2:0]        cmd_sel_i, pins;
    logic [ADDR_W-1:0] cmd_addr_i, rd_addr_i;
    logic [6:0]        cmd_len_i;
    logic [7:0]        wr_data_i, rd_data_o;
    int                fails = 0, compares = 0, busy_cnt = 0, cyc = 0, o;

    sew_link_if sew_link_if_i ();
    sew_ctl #(.QUARTER(4)) sew_ctl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(sew_link_if_i),
        .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_recover_i(cmd_recover_i),
        .cmd_sel_i(cmd_sel_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .wr_data_i(wr_data_i),
        .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .done_o(done_o), .nack_o(nack_o));
    sew_target #(.WR_CYCLES(WRC)) sew_target_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(sew_link_if_i),
        .hw_select_pins_i(pins), .write_protect_i(wp), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
        .standby_o(standby_o), .busy_o(busy_o));
    sew_link_sva sew_link_sva_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl(sew_link_if_i.scl),
        .ctl_sda_o(sew_link_if_i.ctl_sda_o), .ctl_sda_oe(sew_link_if_i.ctl_sda_oe),
        .dev_sda_o(sew_link_if_i.dev_sda_o), .dev_sda_oe(sew_link_if_i.dev_sda_oe), .sda(sew_link_if_i.sda));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // Whole run is about 15k cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
        if (cyc == 60000) begin
            fails = fails + 1;
            stop_test();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task rd(input logic [14:0] a, input logic [7:0] e);
        @(negedge clk_i);
        rd_addr_i = a;
        @(negedge clk_i);
        chk(rd_data_o, e);
    endtask : rd

    // Words are only pushed when the controller will take them, else they linger
    task run(input logic rec, input logic [2:0] sel, input logic [14:0] adr, input logic [6:0] len,
             input logic [7:0] d0, input int push);
        int n;
        @(negedge clk_i);
        busy_cnt = 0;
        cmd_recover_i = rec;
        cmd_sel_i = sel;
        cmd_addr_i = adr;
        cmd_len_i = len;
        cmd_valid_i = 1'b1;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        for (n = 0; n < push; n++) begin
            wr_data_i = d0 + 8'(n);
            wr_valid_i = 1'b1;
            while (wr_ready_o !== 1'b1) @(negedge clk_i);
            @(negedge clk_i);
        end
        wr_valid_i = 1'b0;
        // A hang runs into the cycle ceiling and fails there
        while (done_o !== 1'b1) @(negedge clk_i);
        nk = nack_o;
    endtask : run

    initial begin
        sys_rst_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_recover_i = 1'b0;
        cmd_sel_i = 3'h0;
        cmd_addr_i = 15'h0000;
        cmd_len_i = 7'h01;
        wr_data_i = 8'h00;
        wr_valid_i = 1'b0;
        pins = 3'h5;
        wp = 1'b0;
        rd_addr_i = 15'h0000;
        repeat (16) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk(8'(standby_o), 8'h01);
        repeat (8) @(negedge clk_i);
        run(1'b0, 3'h5, 15'h1234, 7'h01, 8'h3c, 1);
        chk(8'(nk), 8'h00);
        chk(8'(busy_cnt), 8'(WRC));
        chk(8'(busy_o), 8'h00);
        chk(8'(cmd_ready_o), 8'h01);
        rd(15'h1234, 8'h3c);
        chk(8'(standby_o), 8'h01);
        // 66 bytes from offset 62: wraps in page 4, slots 62 and 63 rewritten
        run(1'b0, 3'h5, 15'h013e, 7'h42, 8'h40, 66);
        chk(8'(nk), 8'h00);
        for (o = 0; o < 64; o++) rd({9'h004, 6'(o)}, 8'h40 + 8'((o + 2) & 63) + (((o + 2) & 63) < 2 ? 8'h40 : 8'h00));
        run(1'b0, 3'h4, 15'h1234, 7'h01, 8'h00, 0);
        chk(8'(nk), 8'h01);
        chk(8'(busy_cnt), 8'h00);
        wp = 1'b1;
        run(1'b0, 3'h5, 15'h1234, 7'h01, 8'ha5, 1);
        chk(8'(nk), 8'h00);
        chk(8'(busy_cnt), 8'h00);
        rd(15'h1234, 8'h3c);
        wp = 1'b0;
        run(1'b1, 3'h5, 15'h0000, 7'h01, 8'h00, 0);
        chk(8'(nk), 8'h00);
        chk(8'(standby_o), 8'h01);
        pins = 3'h0;
        run(1'b0, 3'h0, 15'h7fff, 7'h01, 8'h99, 1);
        chk(8'(nk), 8'h00);
        rd(15'h7fff, 8'h99);
        stop_test();
    end
endmodule : serial_eeprom_write_slave_bench
`default_nettype wire
